// [include/asc_pkg.sv]
`default_nettype none
package asc_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFF_MODE0 = 6'h00;
    localparam logic [5:0] OFF_MODE1 = 6'h04;
    localparam logic [5:0] OFF_SLOT0 = 6'h10;
    localparam int unsigned NUM_SLOTS = 4;

    // mode register 0 fields
    localparam int unsigned M0_START_BIT = 0;
    localparam int unsigned M0_SCAN_BIT = 1;
    localparam int unsigned M0_REPEAT_BIT = 2;
    localparam int unsigned M0_PACING_BIT = 3;
    localparam int unsigned M0_BUSY_BIT = 6;
    localparam int unsigned M0_EOC_BIT = 7;

    // mode register 1 fields
    localparam int unsigned M1_CHSEL_LSB = 0;
    localparam int unsigned CHSEL_W = 3;
    localparam int unsigned M1_LIGHT_RUN_BIT = 4;
    localparam int unsigned M1_TRIG_EN_BIT = 5;
    localparam int unsigned M1_REF_ON_BIT = 7;

    // result slot layout: low byte {res[1:0], 0, flag}, high byte res[9:2]
    localparam int unsigned RES_W = 10;
    localparam int unsigned SLOT_FLAG_BIT = 0;
    localparam int unsigned SLOT_LO_LSB = 6;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CHSEL_W-1:0] CHSEL_RST = 3'h0;
    localparam logic SCAN_RST = 1'b0;

    // ------------------------------------------------------------------
    // timing and pacing
    // ------------------------------------------------------------------
    // one conversion state is one peripheral clock, here ref_clk
    localparam int unsigned CONV_STATES = 84;
    localparam int unsigned CONV_CYCLES = CONV_STATES;
    localparam logic [1:0] PACE_LAST = 2'h3;

    // ------------------------------------------------------------------
    // bus answers and sequencer states
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_HALT = 3'h4
    } asc_state_type;
endpackage : asc_pkg
`default_nettype wire

// [design/asc_conv_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module asc_conv_timer #(
    parameter int unsigned CYCLES = asc_pkg::CONV_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic abort,
    output logic done,
    output logic running
);
    localparam int unsigned CNT_W = $clog2(CYCLES);
    // the registered done cycle is itself the last of the CYCLES states
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 2);

    logic [CNT_W-1:0] cnt_r;
    logic run_r;
    logic done_r;
    wire at_last = run_r && (cnt_r == CNT_LAST);

    // restart wins over abort so a start in the halt cycle is not lost
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= at_last && !restart && !abort;
            if (restart) begin
                cnt_r <= '0;
                run_r <= 1'b1;
            end else if (abort || at_last) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    assign done = done_r;
    assign running = run_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    conv_length_a: assert property (
        done |-> $past(restart, CYCLES))
        else $error("conversion did not take the full state count");
endmodule : asc_conv_timer

`default_nettype wire

// [design/asc_top.sv]
// How it works
// - fixed mode converts the one input named by channel select 0..3
// - scan code n converts inputs 0..n ascending; codes 4..7 unused
// - reset clears scan and sets channel select to zero
// - start by software start bit or enabled trigger falling edge
// - busy flag set at start and held during conversion
// - software start during conversion aborts and restarts from the beginning
// - trigger falling edges ignored while converting
// - repeat and scan bits choose one of four modes
// - each completion sets end flag and, paced, raises end interrupt
// - fixed single: convert once, set end, clear busy, interrupt
// - scan single: whole scan once, then end, clear busy, interrupt
// - fixed repeat: busy held, interrupt each or every fourth conversion
// - scan repeat: rescan forever, end and interrupt per scan, busy held
// - clearing repeat finishes current work then clears busy
// - deep halt, or light halt without run bit, stops at once
// - after halt, repeat modes restart from first step; single stays stopped
// - one channel takes 84 peripheral clocks
// - fixed repeat rotates result slots 0..3; otherwise input n to slot n
// - slot stored flag in bit0 set on write, cleared on read
// - reading a result also clears the end flag
// - result left justified: upper 8 in high byte, lower 2 at bits 7:6
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

module asc_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [asc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [asc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_trigger_pin,
    input wire logic light_halt,
    input wire logic deep_halt_a,
    input wire logic [asc_pkg::RES_W-1:0] adc_data,
    output logic [1:0] analog_channel,
    output logic ref_switch_on,
    output logic conv_end_irq
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic reg_hit(
        input logic [asc_pkg::ADDR_W-1:0] addr,
        input logic [5:0] off);
        reg_hit = (addr[asc_pkg::ADDR_W-1:2] == off[5:2]);
    endfunction : reg_hit

    function automatic logic slot_hit(
        input logic [asc_pkg::ADDR_W-1:0] addr);
        slot_hit = (addr[5:4] == asc_pkg::OFF_SLOT0[5:4]);
    endfunction : slot_hit

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r;
    logic arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [asc_pkg::ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic scan_r, repeat_r, pacing_r, light_run_r, trig_en_r, ref_on_r;
    logic [asc_pkg::CHSEL_W-1:0] chsel_r;
    logic busy_r, eoc_r, irq_r, trig_prev_r;
    logic [1:0] cur_ch_r, slot_ptr_r, pace_cnt_r;
    logic [asc_pkg::RES_W-1:0] res_r [asc_pkg::NUM_SLOTS];
    logic [asc_pkg::NUM_SLOTS-1:0] flag_r;
    asc_pkg::asc_state_type state_r, state_nxt;
    logic [1:0] cur_ch_nxt;
    logic tmr_restart, fresh_start;
    logic tmr_done, tmr_running;

    // ------------------------------------------------------------------
    // bus slave: write path
    // ------------------------------------------------------------------
    wire aw_hs = s_axi_awvalid && awready_r;
    wire w_hs = s_axi_wvalid && wready_r;
    wire wr_do = aw_full_r && w_full_r;
    wire aw_full_nxt = (aw_full_r || aw_hs) && !wr_do;
    wire w_full_nxt = (w_full_r || w_hs) && !wr_do;
    wire bvalid_nxt = wr_do || (bvalid_r && !s_axi_bready);
    wire wr_m0_hit = reg_hit(aw_addr_r, asc_pkg::OFF_MODE0);
    wire wr_m1_hit = reg_hit(aw_addr_r, asc_pkg::OFF_MODE1);
    wire wr_mapped = wr_m0_hit || wr_m1_hit || slot_hit(aw_addr_r);
    wire wr_m0 = wr_do && wr_m0_hit && w_strb_r[0];
    wire wr_m1 = wr_do && wr_m1_hit && w_strb_r[0];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= asc_pkg::RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= !aw_full_nxt && !bvalid_nxt;
            wready_r <= !w_full_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_hs) aw_addr_r <= s_axi_awaddr;
            if (w_hs) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                bresp_r <= wr_mapped ? asc_pkg::RESP_OKAY
                                     : asc_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // bus slave: read path; a slot read clears its flag and the end flag
    // ------------------------------------------------------------------
    wire ar_hs = s_axi_arvalid && arready_r;
    wire rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);
    wire rd_slot = ar_hs && slot_hit(s_axi_araddr);
    wire [1:0] rd_idx = s_axi_araddr[3:2];
    wire rd_m0 = reg_hit(s_axi_araddr, asc_pkg::OFF_MODE0);
    wire rd_m1 = reg_hit(s_axi_araddr, asc_pkg::OFF_MODE1);
    wire [7:0] mode0_word = {eoc_r, busy_r, 2'h0, pacing_r, repeat_r,
                             scan_r, 1'b0};
    wire [7:0] mode1_word = {ref_on_r, 1'b0, trig_en_r, light_run_r,
                             1'b0, chsel_r};
    wire [asc_pkg::RES_W-1:0] rd_res = res_r[rd_idx];
    // left justified so software can shift right by six for the value
    wire [15:0] slot_word = {rd_res[9:2], rd_res[1:0], 5'h00,
                             flag_r[rd_idx]};
    wire [31:0] rd_word = rd_m0 ? {24'h0, mode0_word}
                        : rd_m1 ? {24'h0, mode1_word}
                        : slot_hit(s_axi_araddr) ? {16'h0, slot_word}
                        : 32'h0;
    wire rd_mapped = rd_m0 || rd_m1 || slot_hit(s_axi_araddr);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= asc_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_hs) begin
                rdata_r <= rd_word;
                rresp_r <= rd_mapped ? asc_pkg::RESP_OKAY
                                     : asc_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // control bits; mode written together with start takes effect at once
    // ------------------------------------------------------------------
    wire scan_nxt = wr_m0 ? w_data_r[asc_pkg::M0_SCAN_BIT] : scan_r;
    wire repeat_nxt = wr_m0 ? w_data_r[asc_pkg::M0_REPEAT_BIT] : repeat_r;
    wire [asc_pkg::CHSEL_W-1:0] chsel_nxt =
        wr_m1 ? w_data_r[asc_pkg::M1_CHSEL_LSB +: asc_pkg::CHSEL_W]
              : chsel_r;
    wire sw_start_wr = wr_m0 && w_data_r[asc_pkg::M0_START_BIT];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scan_r <= asc_pkg::SCAN_RST;
            chsel_r <= asc_pkg::CHSEL_RST;
            repeat_r <= 1'b0;
            pacing_r <= 1'b0;
            light_run_r <= 1'b0;
            trig_en_r <= 1'b0;
            ref_on_r <= 1'b0;
        end else begin
            scan_r <= scan_nxt;
            repeat_r <= repeat_nxt;
            chsel_r <= chsel_nxt;
            if (wr_m0) pacing_r <= w_data_r[asc_pkg::M0_PACING_BIT];
            if (wr_m1) begin
                light_run_r <= w_data_r[asc_pkg::M1_LIGHT_RUN_BIT];
                trig_en_r <= w_data_r[asc_pkg::M1_TRIG_EN_BIT];
                ref_on_r <= w_data_r[asc_pkg::M1_REF_ON_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // start, halt and completion decode
    // ------------------------------------------------------------------
    wire halt_stop = deep_halt_a || (light_halt && !light_run_r);
    wire trig_fall = trig_prev_r && !ext_trigger_pin;
    wire trig_start = trig_en_r && trig_fall && !busy_r;
    wire start_req = (sw_start_wr || trig_start) && !halt_stop;
    // only the low two bits of channel select matter; codes 4..7 are unused
    wire [1:0] first_ch = scan_nxt ? 2'h0 : chsel_nxt[1:0];
    wire last_in_scan = !scan_r || (cur_ch_r == chsel_r[1:0]);
    wire step_next = tmr_done && !last_in_scan;
    wire complete = tmr_done && last_in_scan;
    wire fixed_rep = repeat_r && !scan_r;
    wire irq_ok = !fixed_rep || !pacing_r
                  || (pace_cnt_r == asc_pkg::PACE_LAST);
    wire [1:0] wr_idx = fixed_rep ? slot_ptr_r : cur_ch_r;
    wire tmr_abort = (state_r == asc_pkg::ST_CONV) && halt_stop;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cur_ch_nxt = cur_ch_r;
        tmr_restart = 1'b0;
        fresh_start = 1'b0;
        case (state_r)
            asc_pkg::ST_IDLE: begin
                if (start_req) begin
                    state_nxt = asc_pkg::ST_CONV;
                    cur_ch_nxt = first_ch;
                    tmr_restart = 1'b1;
                    fresh_start = 1'b1;
                end
            end
            asc_pkg::ST_CONV: begin
                if (halt_stop) begin
                    // single modes stay stopped once the halt ends
                    state_nxt = repeat_r ? asc_pkg::ST_HALT
                                         : asc_pkg::ST_IDLE;
                end else if (start_req) begin
                    cur_ch_nxt = first_ch;
                    tmr_restart = 1'b1;
                    fresh_start = 1'b1;
                end else if (step_next) begin
                    cur_ch_nxt = cur_ch_r + 2'h1;
                    tmr_restart = 1'b1;
                end else if (complete) begin
                    if (repeat_r) begin
                        cur_ch_nxt = first_ch;
                        tmr_restart = 1'b1;
                    end else begin
                        state_nxt = asc_pkg::ST_IDLE;
                    end
                end
            end
            asc_pkg::ST_HALT: begin
                if (!repeat_r) begin
                    state_nxt = asc_pkg::ST_IDLE;
                end else if (!halt_stop) begin
                    state_nxt = asc_pkg::ST_CONV;
                    cur_ch_nxt = first_ch;
                    tmr_restart = 1'b1;
                    fresh_start = 1'b1;
                end
            end
            default: begin
                state_nxt = asc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= asc_pkg::ST_IDLE;
            busy_r <= 1'b0;
            cur_ch_r <= 2'h0;
            trig_prev_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            busy_r <= (state_nxt != asc_pkg::ST_IDLE);
            cur_ch_r <= cur_ch_nxt;
            trig_prev_r <= ext_trigger_pin;
        end
    end

    // ------------------------------------------------------------------
    // end flag, interrupt pulse, pacing and slot rotation
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            eoc_r <= 1'b0;
            irq_r <= 1'b0;
            slot_ptr_r <= 2'h0;
            pace_cnt_r <= 2'h0;
        end else begin
            // a completion in the cycle of a result read still sets the flag
            eoc_r <= complete || (eoc_r && !rd_slot);
            irq_r <= complete && irq_ok;
            if (fresh_start) begin
                slot_ptr_r <= 2'h0;
                pace_cnt_r <= 2'h0;
            end else if (tmr_done && fixed_rep) begin
                slot_ptr_r <= slot_ptr_r + 2'h1;
                pace_cnt_r <= pace_cnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // result slots; results carry no reset, only their flags do
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (tmr_done) res_r[wr_idx] <= adc_data;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_r <= '0;
        end else begin
            for (int i = 0; i < asc_pkg::NUM_SLOTS; i++) begin
                flag_r[i] <= (tmr_done && wr_idx == 2'(i))
                             || (flag_r[i] && !(rd_slot
                                 && rd_idx == 2'(i)));
            end
        end
    end

    asc_conv_timer #(
        .CYCLES(asc_pkg::CONV_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(tmr_restart),
        .abort(tmr_abort),
        .done(tmr_done),
        .running(tmr_running)
    );

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign analog_channel = cur_ch_r;
    assign ref_switch_on = ref_on_r;
    assign conv_end_irq = irq_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence fresh_seq;
        tmr_restart && fresh_start;
    endsequence
    sequence first_ch_seq;
        ##1 (cur_ch_r == $past(first_ch)) && busy_r;
    endsequence

    reset_channel_a: assert property (
        $past(!rst_n) |-> !scan_r && chsel_r == asc_pkg::CHSEL_RST)
        else $error("channel selection not cleared by reset");
    start_busy_a: assert property (
        start_req |=> busy_r && state_r == asc_pkg::ST_CONV)
        else $error("busy not set after start");
    sw_restart_a: assert property (
        (busy_r && sw_start_wr && !halt_stop) |-> fresh_seq ##0 first_ch_seq)
        else $error("software start did not restart conversion");
    trig_ignore_a: assert property (
        (busy_r && trig_fall && !sw_start_wr) |-> !fresh_start)
        else $error("trigger edge accepted during conversion");
    fixed_chan_a: assert property (
        (start_req && !scan_nxt) |=> cur_ch_r == $past(chsel_nxt[1:0]))
        else $error("fixed mode converts wrong input");
    irq_eoc_a: assert property (
        conv_end_irq |-> eoc_r ##1 !conv_end_irq)
        else $error("interrupt not paired with end flag");
    single_end_a: assert property (
        (complete && !repeat_r && !start_req && !halt_stop)
            |=> !busy_r && eoc_r && conv_end_irq)
        else $error("single mode did not end cleanly");
    repeat_busy_a: assert property (
        (complete && repeat_r && !halt_stop) |=> busy_r [*2])
        else $error("busy dropped in repeat mode");
    flag_set_a: assert property (
        (tmr_done && !(rd_slot && rd_idx == wr_idx)) |=> flag_r[$past(wr_idx)])
        else $error("stored flag not set on result write");
    read_clear_a: assert property (
        (rd_slot && !tmr_done) |=> !flag_r[$past(rd_idx)] && !eoc_r)
        else $error("result read did not clear flags");
    halt_stop_a: assert property (
        (halt_stop && !tmr_restart) |=> !tmr_running)
        else $error("converter kept running in halt");
endmodule : asc_top

`default_nettype wire

// [dv/asc_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module asc_analog_model (
    input wire logic ref_clk,
    input wire logic ref_on,
    input wire logic [1:0] chan,
    output logic [9:0] adc_data
);
    // switch open gives no valid level, so keep the value moving
    logic [9:0] junk_r = 10'h155;
    always @(posedge ref_clk) junk_r <= ~junk_r;
    assign adc_data = ref_on ? {chan, 8'hC3} : junk_r;
endmodule : asc_analog_model
`default_nettype wire

// [dv/test_adc_sequencer_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequencer_control;
    logic ref_clk = 1'h0, rst_n = 1'h0, trig = 1'h1, halt = 1'h0;
    logic lhalt = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, ref_on, irq;
    logic [1:0] chan, bresp, rresp;
    logic [9:0] adc;
    int bad_count = 0, total_checks = 0;
    always #5 ref_clk = ~ref_clk;
    asc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_bresp(bresp),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rresp(rresp),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rready(1'h1),
        .s_axi_rvalid(rvalid), .ext_trigger_pin(trig), .light_halt(lhalt),
        .deep_halt_a(halt), .adc_data(adc), .analog_channel(chan),
        .ref_switch_on(ref_on), .conv_end_irq(irq));
    asc_analog_model am (.ref_clk(ref_clk), .ref_on(ref_on), .chan(chan),
        .adc_data(adc));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
    endtask : wr
    task rc(input string n, input logic [5:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hFFFFFFFF);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        chk(n, e, rdata & m);
    endtask : rc
    task automatic wl(input int lo, input int hi);
        int c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (irq !== 1'h1);
        chk("irq delay", 32'h1, 32'(c >= lo && c <= hi));
    endtask : wl
    function automatic logic [31:0] sw(input logic [1:0] c);
        return {16'h0, c, 6'h30, 8'hC1};
    endfunction : sw
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial begin
        #50000 bad_count++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'h1;
        rc("mode1", 6'h04, 32'h0);
        rc("unmapped", 6'h20, 32'h0);
        chk("rresp", 32'h2, {30'h0, rresp});
        wr(6'h20, 32'hFF);
        chk("bresp", 32'h2, {30'h0, bresp});
        wr(6'h04, 32'h83);
        repeat (300) @(posedge ref_clk);
        chk("ref switch", 32'h1, {31'h0, ref_on});
        wr(6'h00, 32'h1);
        wl(83, 89);
        rc("end", 6'h00, 32'h80);
        rc("slot", 6'h1C, sw(2'h3));
        rc("flag", 6'h1C, sw(2'h3) - 32'h1);
        rc("end clear", 6'h00, 32'h0);
        wr(6'h00, 32'h3);
        wl(334, 341);
        for (int i = 0; i < 4; i++) begin
            rc("scan", 6'h10 + 6'(4 * i), sw(2'(i)));
        end
        wr(6'h00, 32'hD);
        wl(334, 341);
        rc("rotate", 6'h10, sw(2'h3));
        rc("busy", 6'h00, 32'h40, 32'h40);
        wr(6'h00, 32'h0);
        wl(60, 86);
        rc("idle", 6'h00, 32'h0, 32'h40);
        wr(6'h04, 32'hA3);
        trig <= 1'h0;
        wl(84, 92);
        trig <= 1'h1;
        wr(6'h00, 32'h1);
        repeat (40) @(posedge ref_clk);
        trig <= 1'h0;
        wl(40, 48);
        wr(6'h00, 32'h1);
        repeat (40) @(posedge ref_clk);
        wr(6'h00, 32'h1);
        wl(83, 86);
        wr(6'h00, 32'h5);
        repeat (20) @(posedge ref_clk);
        lhalt <= 1'h1;
        @(posedge ref_clk);
        rc("halt busy", 6'h00, 32'h40, 32'h40);
        repeat (100) @(posedge ref_clk);
        lhalt <= 1'h0;
        wl(84, 88);
        wr(6'h00, 32'h0);
        wl(60, 86);
        wr(6'h00, 32'h1);
        repeat (20) @(posedge ref_clk);
        halt <= 1'h1;
        @(posedge ref_clk);
        rc("halted", 6'h00, 32'h0, 32'h40);
        halt <= 1'h0;
        repeat (100) @(posedge ref_clk);
        rc("stays stopped", 6'h00, 32'h0, 32'h40);
        end_of_test();
    end
endmodule : test_adc_sequencer_control
`default_nettype wire
